// ### aphi_pkg.sv
package aphi_pkg;
  localparam int NUM_CH = 8;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // Shared bus field positions while writing.
  localparam int BIT_SINGLE = 7;
  localparam int BIT_PAIR = 6;
  localparam int BIT_SIGNED = 5;
  localparam int BIT_HOLD = 4;
  localparam int BIT_PDOWN = 3;
  localparam int BIT_ADDR_LO = 0;
  // Clock and timing.
  localparam int REF_CLK_HZ = 25000000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int BUSY_TO_ACCESS_NS = 50;
  localparam int BUSY_TO_ACCESS_CYC = (BUSY_TO_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_NS = 800;
  localparam int ACQ_CYC = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_NS = 3600;
  localparam int CONV_CYC = (CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host register offsets.
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h1;
  localparam logic [3:0] REG_DATA = 4'h2;
  localparam logic [3:0] REG_IRQ_ST = 4'h3;
  localparam logic [3:0] REG_IRQ_MSK = 4'h4;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h02;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_READ = 1;
endpackage

// ### aphi_if.sv
interface aphi_if;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic busy_n;
  logic [7:0] bus_host;
  logic [7:0] bus_dev;
  logic bus_dev_oe_n;
  logic bus_host_oe_n;
  logic [7:0] bus;
  assign bus = !bus_dev_oe_n ? bus_dev : (!bus_host_oe_n ? bus_host : 8'hFF);
  modport dev (input cs_n, input wr_n, input rd_n, input bus, output busy_n, output bus_dev,
    output bus_dev_oe_n);
  modport host (output cs_n, output wr_n, output rd_n, input busy_n, input bus,
    output bus_host, output bus_host_oe_n);
endinterface

// ### aphi_device.sv
// Decided for this implementation: the register addresses and the plain strobed port.
module aphi_device #(
  parameter int NUM_CH = aphi_pkg::NUM_CH,
  parameter int CONV_CYC = aphi_pkg::CONV_CYC
) (
  // Host port.
  aphi_if.dev port,
  // Analog stand-in.
  input wire logic [NUM_CH*8-1:0] SAMPLE_IN,
  input wire logic REF_CLK,
  input wire logic NRST,
  // Status.
  output logic POWER_DOWN,
  output logic [7:0] CH_CFG
);
  localparam int AW = $clog2(NUM_CH);
  // Only the four- and eight-channel variants exist.
  if (NUM_CH != 4 && NUM_CH != 8) begin : g_bad_ch
    $error("NUM_CH must be 4 or 8.");
  end
  // The conversion timer is sixteen bits wide.
  if (CONV_CYC < 1 || CONV_CYC > 65535) begin : g_bad_conv
    $error("CONV_CYC must lie between 1 and 65535.");
  end
  typedef enum {ST_IDLE, ST_CONV} aphi_st_t;
  aphi_st_t st_r;
  logic wr_d_r;
  logic rd_d_r;
  logic [7:0] held_r [NUM_CH];
  logic [7:0] ram_r [NUM_CH];
  logic [NUM_CH-1:0] cfg_en_r;
  logic [NUM_CH-1:0] cfg_pair_r;
  logic [NUM_CH-1:0] cfg_sgn_r;
  logic [NUM_CH-1:0] pend_pair_r;
  logic [NUM_CH-1:0] pend_sgn_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW-1:0] conv_ch_r;
  logic single_r;
  logic busy_n_r;
  logic pdown_r;
  logic oe_n_r;
  logic [7:0] dout_r;
  logic [7:0] cfg_r;
  logic [15:0] cyc_r;
  logic wr_fall;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;
  logic conv_end;
  logic [AW-1:0] wa;
  // Select gates strobes.
  // A strobe edge counts only while select is low, so a host that lifts
  // select and strobe together does not step the read pointer.
  assign wr_fall = !port.cs_n && wr_d_r && !port.wr_n;
  assign wr_rise = !port.cs_n && !wr_d_r && port.wr_n;
  assign rd_fall = !port.cs_n && rd_d_r && !port.rd_n;
  assign rd_rise = !port.cs_n && !rd_d_r && port.rd_n;
  assign conv_end = st_r == ST_CONV && cyc_r == 16'(CONV_CYC - 1);
  assign wa = port.bus[AW-1:0];
  assign port.busy_n = busy_n_r;
  assign port.bus_dev = dout_r;
  assign port.bus_dev_oe_n = oe_n_r;
  assign POWER_DOWN = pdown_r;
  assign CH_CFG = cfg_r;
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      wr_d_r <= 1'b1;
      rd_d_r <= 1'b1;
    end else begin
      wr_d_r <= port.wr_n | port.cs_n;
      rd_d_r <= port.rd_n | port.cs_n;
    end
  end
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_th
      always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
          held_r[g] <= 8'h00;
        end else if (wr_fall) begin
          held_r[g] <= SAMPLE_IN[g*8 +: 8];
        end
      end
    end
  endgenerate
  // Config latch on rising write; hold-off bit kept here.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_r <= aphi_pkg::CFG_RESET;
    end else if (wr_rise) begin
      cfg_r <= port.bus;
    end
  end
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      single_r <= 1'b0;
      pdown_r <= 1'b0;
    end else if (wr_rise) begin
      single_r <= port.bus[aphi_pkg::BIT_SINGLE];
      pdown_r <= port.bus[aphi_pkg::BIT_PDOWN];
    end
  end
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_en_r <= '0;
      pend_pair_r <= '0;
      pend_sgn_r <= '0;
    end else if (wr_rise) begin
      cfg_en_r[wa] <= 1'b1;
      pend_pair_r[wa] <= port.bus[aphi_pkg::BIT_PAIR];
      pend_sgn_r[wa] <= port.bus[aphi_pkg::BIT_SIGNED];
    end
  end
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_pair_r <= '0;
      cfg_sgn_r <= '0;
    end else if (wr_rise) begin
      cfg_pair_r <= pend_pair_r;
      cfg_sgn_r <= pend_sgn_r;
    end
  end
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= ST_IDLE;
      busy_n_r <= 1'b1;
      cyc_r <= 16'h0000;
      conv_ch_r <= '0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (wr_rise && !port.bus[aphi_pkg::BIT_HOLD]) begin
            st_r <= ST_CONV;
            busy_n_r <= 1'b0;
            cyc_r <= 16'h0000;
            // Multi mode begins at channel 0.
            conv_ch_r <= port.bus[aphi_pkg::BIT_SINGLE] ? wa : '0;
          end
        end
        ST_CONV: begin
          if (cyc_r == 16'(CONV_CYC - 1)) begin
            cyc_r <= 16'h0000;
            if (single_r || conv_ch_r == AW'(NUM_CH - 1)) begin
              st_r <= ST_IDLE;
              busy_n_r <= 1'b1;
            end else begin
              conv_ch_r <= conv_ch_r + AW'(1);
            end
          end else begin
            cyc_r <= cyc_r + 16'h0001;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
  // Result store; signed range offsets the code, pair input subtracts neighbour.
  // The memory has no reset, so a location reads unknown until first converted in single mode, or in multi mode once a write has addressed it.
  always_ff @(posedge REF_CLK) begin
    if (conv_end && (single_r || cfg_en_r[conv_ch_r])) begin
      ram_r[conv_ch_r] <= (cfg_pair_r[conv_ch_r] ? held_r[conv_ch_r] - held_r[conv_ch_r ^ AW'(1)]
        : held_r[conv_ch_r]) ^ {cfg_sgn_r[conv_ch_r], 7'h00};
    end
  end
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rd_ptr_r <= '0;
    end else if (wr_fall && !port.bus[aphi_pkg::BIT_SINGLE]) begin
      rd_ptr_r <= '0;
    end else if (wr_rise && (port.bus[aphi_pkg::BIT_SINGLE] || port.bus[aphi_pkg::BIT_HOLD])) begin
      rd_ptr_r <= wa;
    end else if (rd_rise) begin
      rd_ptr_r <= rd_ptr_r + AW'(1);
    end
  end
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      oe_n_r <= 1'b1;
      dout_r <= 8'h00;
    end else begin
      oe_n_r <= port.cs_n | port.rd_n;
      if (rd_fall) begin
        dout_r <= ram_r[rd_ptr_r];
      end
    end
  end
endmodule

// ### aphi_host.sv
module aphi_host (
  // Device port.
  aphi_if.host port,
  input wire logic REF_CLK,
  input wire logic NRST,
  // Register port.
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [7:0] RDATA,
  output logic IRQ
);
  typedef enum {HS_IDLE, HS_WAIT, HS_LOW, HS_HIGH, HS_GAP} aphi_hst_t;
  aphi_hst_t st_r;
  logic is_rd_r, cs_n_r, wr_n_r, rd_n_r, oe_n_r, irq_r, busy_d_r;
  localparam int IRQ_W_L = aphi_pkg::IRQ_W;
  logic [7:0] wdat_r, cfg_r, res_r, rdata_r;
  logic [IRQ_W_L-1:0] ist_r, imsk_r;
  logic [7:0] cnt_r;
  logic wr_cmd, start, done_ev, read_ev;
  assign port.cs_n = cs_n_r;
  assign port.wr_n = wr_n_r;
  assign port.rd_n = rd_n_r;
  assign port.bus_host = cfg_r;
  assign port.bus_host_oe_n = oe_n_r;
  assign RDATA = rdata_r;
  assign IRQ = irq_r;
  assign wr_cmd = WR_STB && ADDR == aphi_pkg::REG_CMD;
  assign start = wr_cmd && st_r == HS_IDLE && WDATA != 8'h00;
  assign done_ev = !busy_d_r && port.busy_n;
  assign read_ev = st_r == HS_HIGH && is_rd_r;
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      busy_d_r <= 1'b1;
    end else begin
      busy_d_r <= port.busy_n;
    end
  end
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      wdat_r <= 8'h00;
    end else if (WR_STB && ADDR == aphi_pkg::REG_DATA) begin
      wdat_r <= WDATA;
    end
  end
  // Bus access sequencer with select around each strobe.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= HS_IDLE;
      cs_n_r <= 1'b1;
      wr_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      is_rd_r <= 1'b0;
      cfg_r <= 8'h00;
      res_r <= 8'h00;
      cnt_r <= 8'h00;
    end else begin
      case (st_r)
        HS_IDLE: begin
          if (start) begin
            is_rd_r <= WDATA == aphi_pkg::CMD_READ;
            cfg_r <= wdat_r;
            cnt_r <= 8'h00;
            st_r <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (!port.busy_n) begin
            cnt_r <= 8'h00;
          end else if (cnt_r == 8'(aphi_pkg::BUSY_TO_ACCESS_CYC)) begin
            st_r <= HS_LOW;
            cnt_r <= 8'h00;
            cs_n_r <= 1'b0;
            oe_n_r <= is_rd_r;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        HS_LOW: begin
          wr_n_r <= is_rd_r;
          rd_n_r <= !is_rd_r;
          if (cnt_r == 8'(aphi_pkg::STROBE_CYC)) begin
            st_r <= HS_HIGH;
            res_r <= port.bus;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        HS_HIGH: begin
          wr_n_r <= 1'b1;
          rd_n_r <= 1'b1;
          cnt_r <= 8'h00;
          st_r <= HS_GAP;
        end
        HS_GAP: begin
          cs_n_r <= 1'b1;
          oe_n_r <= 1'b1;
          if (cnt_r == 8'(aphi_pkg::ACQ_CYC)) begin
            st_r <= HS_IDLE;
          end else begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end
  // Sticky interrupt status; a set in the clear cycle wins.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ist_r <= '0;
      imsk_r <= '0;
      irq_r <= 1'b0;
    end else begin
      if (WR_STB && ADDR == aphi_pkg::REG_IRQ_MSK) begin
        imsk_r <= WDATA[IRQ_W_L-1:0];
      end
      ist_r <= (ist_r & ~((WR_STB && ADDR == aphi_pkg::REG_IRQ_ST) ? WDATA[IRQ_W_L-1:0] : '0))
        | {read_ev, done_ev};
      irq_r <= |(ist_r & imsk_r);
    end
  end
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rdata_r <= 8'h00;
    end else if (RD_STB) begin
      case (ADDR)
        aphi_pkg::REG_STAT: rdata_r <= {6'h00, port.busy_n, st_r != HS_IDLE};
        aphi_pkg::REG_DATA: rdata_r <= res_r;
        aphi_pkg::REG_IRQ_ST: rdata_r <= {6'h00, ist_r};
        aphi_pkg::REG_IRQ_MSK: rdata_r <= {6'h00, imsk_r};
        default: rdata_r <= 8'h00;
      endcase
    end
  end
endmodule

// ### aphi_props.sv
module aphi_props #(
  parameter int NUM_CH = 8,
  parameter int CONV_CYC = 90
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic NRST,
  // Link signals.
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic busy_n,
  input wire logic bus_dev_oe_n,
  input wire logic bus_host_oe_n
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  int low_cnt;
  int hi_cnt;
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= busy_n ? 0 : low_cnt + 1;
    end
  end
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      hi_cnt <= 999;
    end else begin
      hi_cnt <= !wr_n ? 0 : (hi_cnt < 999 ? hi_cnt + 1 : hi_cnt);
    end
  end
  property p_oe_read; $fell(bus_dev_oe_n) |-> $past(!cs_n && !rd_n); endproperty
  a_oe_read: assert property (p_oe_read) else $error("Bus driven without read.");
  property p_oe_idle; cs_n && $past(cs_n) |-> bus_dev_oe_n; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("Bus driven while idle.");
  property p_no_fight; bus_dev_oe_n || bus_host_oe_n; endproperty
  a_no_fight: assert property (p_no_fight) else $error("Both ends drive bus.");
  property p_busy_start; $fell(busy_n) |-> $past(wr_n) && (!$past(wr_n, 2) || !$past(wr_n, 3));
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("Busy without write.");
  property p_busy_len; $rose(busy_n) |-> low_cnt >= CONV_CYC; endproperty
  a_busy_len: assert property (p_busy_len) else $error("Busy too short.");
  property p_busy_max; low_cnt <= NUM_CH * CONV_CYC + 8; endproperty
  a_busy_max: assert property (p_busy_max) else $error("Busy too long.");
  property p_rd_wait; $fell(rd_n) |-> busy_n && $past(busy_n, 2); endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("Read too soon.");
  property p_wr_wait; $fell(wr_n) |-> busy_n && $past(busy_n, 2); endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("Write too soon.");
  property p_acq; $fell(wr_n) |-> hi_cnt >= aphi_pkg::ACQ_CYC; endproperty
  a_acq: assert property (p_acq) else $error("Acquisition too short.");
  property p_sel; !wr_n || !rd_n |-> !cs_n; endproperty
  a_sel: assert property (p_sel) else $error("Strobe without select.");
  c_multi: cover property ($rose(busy_n) && low_cnt > 2 * CONV_CYC);
  c_read: cover property ($fell(bus_dev_oe_n));
  c_write: cover property ($fell(busy_n));
endmodule

// ### adc_parallel_host_interface_tb.sv
module adc_parallel_host_interface_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CONV = 6;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [7:0] rdata;
  logic irq;
  logic irq_a;
  logic power_down;
  logic [7:0] ch_cfg;
  logic [63:0] sample_in = 64'h0;
  logic [63:0] snap;
  logic [7:0] mem [8];
  logic [1:0] pend [8] = '{default: 2'b00};
  logic [1:0] act [8] = '{default: 2'b00};
  logic [7:0] got;
  int failures = 0;
  int comparisons = 0;
  int low_seen;
  always #20 ref_clk = ~ref_clk;
  aphi_if aphi_if_inst ();
  aphi_device #(.NUM_CH(8), .CONV_CYC(CONV)) aphi_device_inst (.port(aphi_if_inst.dev),
    .SAMPLE_IN(sample_in), .REF_CLK(ref_clk), .NRST(nrst), .POWER_DOWN(power_down),
    .CH_CFG(ch_cfg));
  aphi_host aphi_host_inst (.port(aphi_if_inst.host), .REF_CLK(ref_clk), .NRST(nrst),
    .ADDR(addr), .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata), .IRQ(irq));
  aphi_props #(.NUM_CH(8), .CONV_CYC(CONV)) aphi_props_inst (.REF_CLK(ref_clk), .NRST(nrst),
    .cs_n(aphi_if_inst.cs_n), .wr_n(aphi_if_inst.wr_n), .rd_n(aphi_if_inst.rd_n),
    .busy_n(aphi_if_inst.busy_n), .bus_dev_oe_n(aphi_if_inst.bus_dev_oe_n),
    .bus_host_oe_n(aphi_if_inst.bus_host_oe_n));
  function automatic logic [7:0] calc(logic [63:0] s, int ch, logic [1:0] m);
    logic [7:0] v;
    v = m[1] ? s[ch*8+:8] - s[(ch^1)*8+:8] : s[ch*8+:8];
    return m[0] ? v ^ 8'h80 : v;
  endfunction
  task automatic check(string name, logic [7:0] exp, logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic reg_wr(logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic reg_rd(logic [3:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic conv(logic [7:0] cfg);
    int n;
    snap = sample_in;
    act = pend;
    pend[cfg[2:0]] = cfg[6:5];
    reg_wr(aphi_pkg::REG_DATA, cfg);
    reg_wr(aphi_pkg::REG_CMD, aphi_pkg::CMD_WRITE);
    n = 0;
    while (aphi_if_inst.wr_n !== 1'b0 && n < 50) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("write strobe", 8'h01, {7'h0, n < 50});
    repeat (3) @(posedge ref_clk);
    sample_in <= {$urandom, $urandom};
    low_seen = 0;
    for (n = 0; n < 8 * CONV + 80; n++) begin
      @(posedge ref_clk);
      if (aphi_if_inst.busy_n === 1'b0) low_seen++;
    end
    check("hold-off", {7'h0, cfg[4]}, {7'h0, low_seen == 0});
    check("config", cfg, ch_cfg);
    if (!cfg[4]) begin
      for (n = 0; n < 8; n++) begin
        if (!cfg[7] || n == cfg[2:0]) mem[n] = calc(snap, n, act[n]);
      end
    end
  endtask
  task automatic fetch(logic [7:0] exp);
    reg_wr(aphi_pkg::REG_CMD, aphi_pkg::CMD_READ);
    repeat (40) @(posedge ref_clk);
    reg_rd(aphi_pkg::REG_DATA);
    check("result", exp, got);
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    failures++;
    report_and_stop();
  end
  initial begin
    int k;
    int c;
    logic [7:0] tbl [4];
    tbl = '{8'hA3, 8'hA3, 8'hC2, 8'hC2};
    void'($urandom(44187));
    sample_in = {$urandom, $urandom};
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    reg_wr(aphi_pkg::REG_IRQ_MSK, 8'h03);
    for (k = 0; k < 12; k++) begin
      c = k < 8 ? k : $urandom_range(7);
      conv(8'h80 | c[7:0]);
      fetch(mem[c]);
    end
    irq_a = irq;
    reg_rd(aphi_pkg::REG_IRQ_ST);
    check("irq status", 8'h03, got);
    reg_wr(aphi_pkg::REG_IRQ_MSK, 8'h00);
    @(posedge ref_clk);
    #1 check("irq mask", 8'h01, {7'h0, irq_a ^ irq});
    reg_wr(aphi_pkg::REG_IRQ_ST, 8'h03);
    reg_wr(4'hF, 8'hFF);
    reg_rd(aphi_pkg::REG_IRQ_ST);
    check("irq clear", 8'h00, got);
    reg_rd(aphi_pkg::REG_STAT);
    check("status", 8'h02, got);
    conv(8'h15);
    fetch(mem[5]);
    fetch(mem[6]);
    conv(8'h18);
    check("power-down on", 8'h01, {7'h0, power_down});
    conv(8'h10);
    check("power-down off", 8'h00, {7'h0, power_down});
    conv(8'h00);
    for (k = 0; k < 8; k++) fetch(mem[k]);
    for (k = 0; k < 4; k++) begin
      conv(tbl[k]);
      fetch(mem[tbl[k][2:0]]);
    end
    report_and_stop();
  end
endmodule
